// *** verilog/fsl_pkg.sv ***
/*
 * Constants shared by the fault status logger: error codes, register map,
 * field positions, reset values, timing counts and the bus state type.
 * Assumes a 200 MHz controller clock.
 */
package fsl_pkg;
    // error codes and class flag
    localparam logic [15:0] CODE_RESET  = 16'hF000;
    localparam logic [15:0] CODE_DLOAD  = 16'hF001;
    localparam logic [15:0] CODE_WDOG   = 16'hF002;
    localparam logic [15:0] CODE_MEMMOD = 16'hF003;
    localparam logic [15:0] CODE_XFER   = 16'hF004;
    localparam logic [15:0] CODE_INTEG  = 16'hF005;
    localparam logic [15:0] CODE_INCOMP = 16'hF006;
    localparam logic [15:0] CODE_FUNC   = 16'hF010;
    localparam logic        CLASS_REC    = 1'b0;
    localparam logic        CLASS_NONREC = 1'b1;
    localparam int          LOG_DEPTH    = 10;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL    = 5'h00;
    localparam logic [4:0] OFS_STATUS  = 5'h04;
    localparam logic [4:0] OFS_LAST    = 5'h08;
    localparam logic [4:0] OFS_LOGSEL  = 5'h0C;
    localparam logic [4:0] OFS_LOGDATA = 5'h10;

    // field positions
    localparam int CTRL_CLEAR_BIT = 0;
    localparam int ST_REC_BIT     = 0;
    localparam int ST_NONREC_BIT  = 1;
    localparam int ST_UNLOCK_BIT  = 2;
    localparam int ST_FORCE_BIT   = 3;
    localparam int ST_RUN_BIT     = 4;
    localparam int ST_CNT_LSB     = 8;
    localparam int ENT_CLASS_BIT  = 16;
    localparam int ENT_VALID_BIT  = 31;

    // reset values
    localparam logic [3:0]  LOGSEL_RST = 4'h0;
    localparam logic [16:0] ENTRY_RST  = 17'h00000;

    // timing
    localparam int unsigned CLK_KHZ           = 200000;
    localparam int unsigned SCAN_LIMIT_MS     = 3000;
    localparam int unsigned SCAN_LIMIT_CYCLES = SCAN_LIMIT_MS * CLK_KHZ;
    localparam int unsigned BLINK_MS          = 250;
    localparam int unsigned BLINK_CYCLES      = BLINK_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } fsl_bus_e;
endpackage : fsl_pkg

// *** verilog/fsl_top.sv ***
/*
 * Fault status logger: classifies fault events, drives the status
 * indicators, keeps a last-fault record and a ten-deep nonrecoverable log,
 * runs the program-scan watchdog and issues the recovery clear pulses.
 * Assumes all event inputs are synchronous to clk and registers are
 * reached over an Avalon-MM slave with waitrequest.
 */
`timescale 1ns/1ps
`default_nettype none
module fsl_top #(
    parameter int unsigned SCAN_LIMIT_CYCLES = fsl_pkg::SCAN_LIMIT_CYCLES,
    parameter int unsigned BLINK_CYCLES      = fsl_pkg::BLINK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        power_ok,
    input  wire logic        prog_running,
    input  wire logic        force_active,
    input  wire logic        scan_start,
    input  wire logic        ctrl_reset_done,
    input  wire logic        user_data_lost_flag,
    input  wire logic        evt_unexp_reset,
    input  wire logic        evt_dl_power_loss,
    input  wire logic        evt_dl_cable_pull,
    input  wire logic        evt_ram_test_fail,
    input  wire logic        evt_mm_hw_fault,
    input  wire logic        evt_mm_conn_fault,
    input  wire logic        evt_mm_incompat,
    input  wire logic        evt_mm_xfer_fail,
    input  wire logic        evt_prog_integ_fail,
    input  wire logic        evt_prog_incompat,
    input  wire logic        evt_func_unsupported,
    input  wire logic        ext_fault_valid,
    input  wire logic [15:0] ext_fault_code,
    input  wire logic        ext_fault_nonrec,
    output logic             power_led,
    output logic             run_led,
    output logic             force_led,
    output logic             fault_led_red,
    output logic             clear_user_data,
    output logic             clear_program
);
    localparam int DEPTH = fsl_pkg::LOG_DEPTH;
    localparam int IW    = $clog2(DEPTH);

    fsl_pkg::fsl_bus_e bus_q;
    logic [31:0] rdata_q;
    logic [16:0] last_q;
    logic        last_valid_q;
    logic [16:0] log_q [DEPTH];
    logic [3:0]  log_cnt_q;
    logic [3:0]  logsel_q;
    logic        rec_pend_q;
    logic        nonrec_q;
    logic        unlock_q;
    logic [31:0] wd_cnt_q;
    logic        wd_armed_q;
    logic [31:0] blink_cnt_q;
    logic        blink_ph_q;

    // bus decode
    wire bus_req   = avs_read | avs_write;
    wire bus_take  = (bus_q == fsl_pkg::BUS_ACK);
    wire wr_take   = bus_take & avs_write;
    wire hit_ctrl  = (avs_address == fsl_pkg::OFS_CTRL);
    wire hit_stat  = (avs_address == fsl_pkg::OFS_STATUS);
    wire hit_last  = (avs_address == fsl_pkg::OFS_LAST);
    wire hit_lsel  = (avs_address == fsl_pkg::OFS_LOGSEL);
    wire hit_ldat  = (avs_address == fsl_pkg::OFS_LOGDATA);
    wire clr_req   = wr_take & hit_ctrl & avs_byteenable[0]
                     & avs_writedata[fsl_pkg::CTRL_CLEAR_BIT];
    wire lsel_wr   = wr_take & hit_lsel & avs_byteenable[0];
    assign avs_waitrequest = bus_req & ~bus_take;
    assign avs_readdata    = rdata_q;

    // watchdog on the program scan
    wire wd_trip = wd_armed_q & prog_running & (wd_cnt_q == SCAN_LIMIT_CYCLES);

    // cause to code mapping, watchdog first
    wire any_dload  = evt_dl_power_loss | evt_dl_cable_pull | evt_ram_test_fail;
    wire any_memmod = evt_mm_hw_fault | evt_mm_conn_fault | evt_mm_incompat;
    wire integ_run  = evt_prog_integ_fail & prog_running;
    wire named_rec  = evt_unexp_reset | any_dload | any_memmod | evt_mm_xfer_fail
                      | integ_run | evt_prog_incompat | evt_func_unsupported;
    wire fault_hit  = wd_trip | named_rec | ext_fault_valid;
    wire [15:0] sel_code =
        wd_trip              ? fsl_pkg::CODE_WDOG   :
        evt_unexp_reset      ? fsl_pkg::CODE_RESET  :
        any_dload            ? fsl_pkg::CODE_DLOAD  :
        any_memmod           ? fsl_pkg::CODE_MEMMOD :
        evt_mm_xfer_fail     ? fsl_pkg::CODE_XFER   :
        integ_run            ? fsl_pkg::CODE_INTEG  :
        evt_prog_incompat    ? fsl_pkg::CODE_INCOMP :
        evt_func_unsupported ? fsl_pkg::CODE_FUNC   :
        ext_fault_code;
    wire sel_class = wd_trip ? fsl_pkg::CLASS_NONREC :
                     named_rec ? fsl_pkg::CLASS_REC : ext_fault_nonrec;
    wire [16:0] sel_entry  = {sel_class, sel_code};
    wire        rec_set    = fault_hit & (sel_class == fsl_pkg::CLASS_REC);
    wire        nonrec_set = fault_hit & (sel_class == fsl_pkg::CLASS_NONREC);
    wire        recover    = fault_hit & (sel_code == fsl_pkg::CODE_RESET
                                          || sel_code == fsl_pkg::CODE_WDOG);

    // pending flags: a new fault wins over a clear in the same cycle
    wire rec_pend_d = rec_set | (rec_pend_q & ~clr_req);
    wire nonrec_d   = nonrec_set | (nonrec_q & ~(clr_req & unlock_q));
    wire unlock_d   = ctrl_reset_done | (unlock_q & ~nonrec_set & ~(clr_req & unlock_q));

    wire blink_tick = (blink_cnt_q == BLINK_CYCLES - 1);
    wire [IW-1:0] rd_idx = logsel_q[IW-1:0];
    wire          rd_ok  = (logsel_q < log_cnt_q);

    wire [31:0] stat_word = {16'h0000, 4'h0, log_cnt_q, 3'h0,
                             prog_running, force_active, unlock_q, nonrec_q, rec_pend_q};
    wire [31:0] last_word = {last_valid_q, 14'h0000, last_q};
    wire [31:0] ldat_word = rd_ok ? {1'b1, 14'h0000, log_q[rd_idx]} : 32'h00000000;
    wire [31:0] rd_mux    = hit_stat ? stat_word :
                            hit_last ? last_word :
                            hit_lsel ? {28'h0000000, logsel_q} :
                            hit_ldat ? ldat_word : 32'h00000000;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_q   <= fsl_pkg::BUS_IDLE;
            rdata_q <= 32'h00000000;
        end else begin
            case (bus_q)
                fsl_pkg::BUS_IDLE: begin
                    if (bus_req) begin
                        bus_q   <= fsl_pkg::BUS_ACK;
                        rdata_q <= avs_read ? rd_mux : 32'h00000000;
                    end
                end
                default: bus_q <= fsl_pkg::BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            logsel_q   <= fsl_pkg::LOGSEL_RST;
            rec_pend_q <= 1'b0;
            nonrec_q   <= 1'b0;
            unlock_q   <= 1'b0;
        end else begin
            if (lsel_wr) logsel_q <= avs_writedata[3:0];
            rec_pend_q <= rec_pend_d;
            nonrec_q   <= nonrec_d;
            unlock_q   <= unlock_d;
        end
    end

    // last fault of either class
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            last_q       <= fsl_pkg::ENTRY_RST;
            last_valid_q <= 1'b0;
        end else if (fault_hit) begin
            last_q       <= sel_entry;
            last_valid_q <= 1'b1;
        end
    end

    // nonrecoverable history, newest at entry 0
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_log
            if (gi == 0) begin : g_head
                always_ff @(posedge clk or posedge sys_rst) begin
                    if (sys_rst) log_q[gi] <= fsl_pkg::ENTRY_RST;
                    else if (nonrec_set) log_q[gi] <= sel_entry;
                end
            end else begin : g_tail
                always_ff @(posedge clk or posedge sys_rst) begin
                    if (sys_rst) log_q[gi] <= fsl_pkg::ENTRY_RST;
                    else if (nonrec_set) log_q[gi] <= log_q[gi-1];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) log_cnt_q <= 4'h0;
        else if (nonrec_set && log_cnt_q < 4'(DEPTH)) log_cnt_q <= log_cnt_q + 4'h1;
    end

    // scan timer restarts on every scan start and trips once per scan
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wd_cnt_q   <= 32'h00000000;
            wd_armed_q <= 1'b0;
        end else if (scan_start) begin
            wd_cnt_q   <= 32'h00000000;
            wd_armed_q <= 1'b1;
        end else if (wd_trip) begin
            wd_armed_q <= 1'b0;
        end else if (wd_armed_q && prog_running) begin
            wd_cnt_q <= wd_cnt_q + 32'h00000001;
        end
    end

    // flash timebase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            blink_cnt_q <= 32'h00000000;
            blink_ph_q  <= 1'b0;
        end else if (blink_tick) begin
            blink_cnt_q <= 32'h00000000;
            blink_ph_q  <= ~blink_ph_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h00000001;
        end
    end

    // indicators and recovery pulses
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_led       <= 1'b0;
            run_led         <= 1'b0;
            force_led       <= 1'b0;
            fault_led_red   <= 1'b0;
            clear_user_data <= 1'b0;
            clear_program   <= 1'b0;
        end else begin
            power_led       <= power_ok;
            run_led         <= prog_running;
            force_led       <= force_active;
            fault_led_red   <= nonrec_q | (rec_pend_q & blink_ph_q);
            clear_user_data <= recover & user_data_lost_flag;
            clear_program   <= recover & ~user_data_lost_flag;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_power_run_leds: assert property (power_ok && prog_running |=> power_led && run_led)
        else $error("power or run indicator dark in normal operation");
    chk_force_led_follow: assert property (force_active != $past(force_active)
            |=> force_led == $past(force_active))
        else $error("force indicator does not follow force state");
    chk_last_capture: assert property (fault_hit |=> last_q == $past(sel_entry) && last_valid_q)
        else $error("last fault record not captured");
    chk_log_shift: assert property (nonrec_set |=> log_q[0] == $past(sel_entry)
            && log_q[DEPTH-1] == $past(log_q[DEPTH-2]))
        else $error("nonrecoverable log did not shift");
    chk_rec_clear: assert property (rec_pend_q && clr_req && !rec_set |=> !rec_pend_q)
        else $error("recoverable fault not cleared by clear request");
    chk_nonrec_hold: assert property (nonrec_q && clr_req && !unlock_q |=> nonrec_q)
        else $error("nonrecoverable fault cleared without reset");
    chk_steady_red: assert property (nonrec_q [*2] |=> fault_led_red)
        else $error("fault indicator not steady red");
    chk_flash_red: assert property (rec_pend_q && !nonrec_q
            |=> fault_led_red == $past(blink_ph_q))
        else $error("recoverable fault indicator not flashing");
    chk_wdog_log: assert property (wd_trip |=> nonrec_q
            && last_q == {fsl_pkg::CLASS_NONREC, fsl_pkg::CODE_WDOG})
        else $error("watchdog trip not logged");
    chk_reset_code: assert property (evt_unexp_reset && !wd_trip
            |=> last_q == {fsl_pkg::CLASS_REC, fsl_pkg::CODE_RESET} && rec_pend_q)
        else $error("unexpected reset not logged");
    chk_recover_policy: assert property (recover |=> (clear_user_data ^ clear_program)
            && clear_user_data == $past(user_data_lost_flag))
        else $error("recovery clear policy wrong");
endmodule : fsl_top
`default_nettype wire

// *** testbench/fsl_lamp_model.sv ***
/* Model of the fault lamp as seen by an observer: flash half period and change count.
   Assumes fault_led_red is a registered output on clk. */
`timescale 1ns/1ps
`default_nettype none
module fsl_lamp_model (
    input  wire logic   clk,
    input  wire logic   sys_rst,
    input  wire logic   fault_led_red,
    output logic [31:0] half_q,
    output logic [31:0] toggles_q
);
    logic        prev_q;
    logic [31:0] cnt_q;
    // cycles between two lamp changes; steady red shows no changes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_q    <= 1'b0;
            cnt_q     <= 32'h1;
            half_q    <= 32'h0;
            toggles_q <= 32'h0;
        end else if (fault_led_red != prev_q) begin
            prev_q    <= fault_led_red;
            half_q    <= cnt_q;
            cnt_q     <= 32'h1;
            toggles_q <= toggles_q + 32'h1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule : fsl_lamp_model
`default_nettype wire

// *** testbench/test_fault_status_logger.sv ***
/* Testbench of the fault status logger: bus tasks, fault events, lamp checks.
   Assumes short sim counts: scan limit 50 cycles, flash half period 4 cycles. */
`timescale 1ns/1ps
`default_nettype none
module test_fault_status_logger;
    logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, t0, half_q, toggles_q;
    logic [3:0]  avs_byteenable;
    logic        power_ok, prog_running, force_active, scan_start, ctrl_reset_done;
    logic        user_data_lost_flag, ext_fault_valid, ext_fault_nonrec;
    logic [15:0] ext_fault_code;
    logic [10:0] evt;
    logic        power_led, run_led, force_led, fault_led_red, clear_user_data, clear_program;
    int          miscompares, n_tests, n_cu, n_cp;
    logic [15:0] codes [11] = '{16'hF000, 16'hF001, 16'hF001, 16'hF001, 16'hF003, 16'hF003,
                                16'hF003, 16'hF004, 16'hF005, 16'hF006, 16'hF010};

    fsl_top #(.SCAN_LIMIT_CYCLES(50), .BLINK_CYCLES(4)) fsl_top_i (
        .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .power_ok, .prog_running,
        .force_active, .scan_start, .ctrl_reset_done, .user_data_lost_flag,
        .evt_unexp_reset(evt[0]), .evt_dl_power_loss(evt[1]), .evt_dl_cable_pull(evt[2]),
        .evt_ram_test_fail(evt[3]), .evt_mm_hw_fault(evt[4]), .evt_mm_conn_fault(evt[5]),
        .evt_mm_incompat(evt[6]), .evt_mm_xfer_fail(evt[7]), .evt_prog_integ_fail(evt[8]),
        .evt_prog_incompat(evt[9]), .evt_func_unsupported(evt[10]), .ext_fault_valid,
        .ext_fault_code, .ext_fault_nonrec, .power_led, .run_led, .force_led, .fault_led_red,
        .clear_user_data, .clear_program);
    fsl_lamp_model fsl_lamp_model_i (.clk, .sys_rst, .fault_led_red, .half_q, .toggles_q);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // recovery pulses are counted where they are settled
    always @(negedge clk) begin
        if (clear_user_data === 1'b1) n_cu++;
        if (clear_program === 1'b1) n_cp++;
    end

    task end_sim;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int k;
        avs_address   <= a;
        avs_writedata <= wd;
        avs_write     <= wr;
        avs_read      <= !wr;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
        if (k == 50) begin
            miscompares++;
            end_sim();
        end
    endtask : bus

    task chk_rd(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : chk_rd

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    initial begin
        {avs_address, avs_read, avs_write, avs_writedata, prog_running, force_active} = '0;
        {scan_start, ctrl_reset_done, user_data_lost_flag, ext_fault_valid, evt} = '0;
        {ext_fault_code, miscompares, n_tests, n_cu, n_cp} = '0;
        avs_byteenable = 4'hF;
        ext_fault_nonrec = 1'b1;
        power_ok = 1'b1;
        sys_rst = 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        prog_running <= 1'b1;
        force_active <= 1'b1;
        cyc(3);
        @(negedge clk);
        chk(power_led, 1'b1);
        chk(run_led, 1'b1);
        chk(force_led, 1'b1);
        @(posedge clk);
        force_active <= 1'b0;
        prog_running <= 1'b0;
        cyc(3);
        @(negedge clk);
        chk(force_led, 1'b0);
        chk(run_led, 1'b0);
        @(posedge clk);
        chk_rd(5'h14, 32'h0);
        $display("test indicators done");
        user_data_lost_flag <= 1'b1;
        prog_running <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            evt <= 11'(1 << i);
            @(posedge clk);
            evt <= '0;
            chk_rd(5'h08, {16'h8000, codes[i]});
            @(negedge clk);
            t0 = toggles_q;
            cyc(12);
            @(negedge clk);
            chk(half_q, 32'h4);
            chk(32'(toggles_q - t0 >= 2), 32'h1);
            @(posedge clk);
            bus(1'b1, 5'h00, 32'h1);
            bus(1'b0, 5'h04, 32'h0);
            chk(rd[1:0], 2'b00);
        end
        chk(n_cu, 1);
        chk(n_cp, 0);
        $display("test codes done");
        user_data_lost_flag <= 1'b0;
        scan_start <= 1'b1;
        @(posedge clk);
        scan_start <= 1'b0;
        cyc(60);
        chk_rd(5'h08, 32'h8001F002);
        @(negedge clk);
        t0 = toggles_q;
        cyc(16);
        @(negedge clk);
        chk(fault_led_red, 1'b1);
        chk(toggles_q, t0);
        chk(n_cp, 1);
        @(posedge clk);
        prog_running <= 1'b0;
        bus(1'b1, 5'h00, 32'h1);
        bus(1'b0, 5'h04, 32'h0);
        chk(rd[1], 1'b1);
        ctrl_reset_done <= 1'b1;
        @(posedge clk);
        ctrl_reset_done <= 1'b0;
        bus(1'b1, 5'h00, 32'h1);
        bus(1'b0, 5'h04, 32'h0);
        chk(rd[1], 1'b0);
        $display("test watchdog done");
        for (int i = 1; i < 12; i++) begin
            ext_fault_code <= 16'h0E00 + 16'(i);
            ext_fault_valid <= 1'b1;
            @(posedge clk);
            ext_fault_valid <= 1'b0;
            @(posedge clk);
        end
        bus(1'b0, 5'h04, 32'h0);
        chk(rd[11:8], 4'hA);
        bus(1'b1, 5'h0C, 32'h0);
        chk_rd(5'h10, 32'h80010E0B);
        bus(1'b1, 5'h0C, 32'h9);
        chk_rd(5'h10, 32'h80010E02);
        bus(1'b1, 5'h0C, 32'hA);
        chk_rd(5'h10, 32'h0);
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk_rd(5'h04, 32'h0);
        chk_rd(5'h08, 32'h0);
        $display("test log done");
        end_sim();
    end
endmodule : test_fault_status_logger
`default_nettype wire
